/* verilog/lss_top.sv */
`timescale 1ns/1ns
// What this block does
// RL1: Byte/half/word steering to word, half, byte devices
// RL2: Refuse transfers wider than addressed device
// RL3: Lane selects from size and low address bits
// RL4: Loads right-justify byte/halfword, word keeps lane order
// RL5: Stores replicate byte/halfword onto selected lanes
// RL6: Left-justified narrow slaves only partly handled: width checked, lanes still follow the address
// RL7: Data side port enables as build parameters
// RL8: Instruction side port enables as build parameters
// RL9: Local-bus writes complete every two clocks
// RL10: Single-cycle back-to-back reads when done same cycle
// RL11: Memory is big-endian, MSB at lowest address
// RL12: Byte accesses unaffected by byte ordering
// RL13: Address strobe high only in first cycle
// RL14: Read/write strobe falls after done, same type excepted
// RL15: Memory side done ends transfer, validates read data
// RL16: Write data held until cycle after done
// RL17: Unfilled load bits zero-extended
module lss_top #(
  parameter bit data_side_periph_bus_en  = 1'b1,
  parameter bit data_side_local_mem_en   = 1'b1,
  parameter bit instr_side_periph_bus_en = 1'b1,
  parameter bit instr_side_local_mem_en  = 1'b1
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire logic [11:0]           paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire lss_pkg::lss_core_req_t core_req,
  output logic                       core_req_ack,
  output lss_pkg::lss_core_rsp_t     core_rsp,
  output lss_pkg::lss_mem_req_t      lmb_req,
  input  wire logic [31:0]           lmb_rdata,
  input  wire logic                  data_xfer_done,
  output lss_pkg::lss_mem_req_t      pb_req,
  input  wire logic [31:0]           pb_rdata,
  input  wire logic                  pb_xfer_done
);

  // ---------------------------------------------------------------
  // Lane decode helpers
  // ---------------------------------------------------------------
  // Lane selects; byte_en[3] is lane 0 at the lowest byte address
  function automatic logic [3:0] lane_sel(input lss_pkg::lss_size_t sz, input logic [1:0] a);
    logic [3:0] be;
    be = 4'h0;
    case (sz)
      lss_pkg::LSS_SZ_BYTE: be = 4'h8 >> a;                           // [RL3]
      lss_pkg::LSS_SZ_HALF: be = a[1] ? 4'h3 : 4'hc;                  // [RL3]
      default:              be = 4'hf;                                // [RL3]
    endcase
    return be;
  endfunction

  // Aligned and not wider than the device behind the port
  function automatic logic req_ok(input lss_pkg::lss_size_t sz, input logic [1:0] a,
                                  input logic [1:0] dev_w);
    logic ok;
    ok = 1'b1;
    case (sz)
      lss_pkg::LSS_SZ_BYTE: ok = 1'b1;
      lss_pkg::LSS_SZ_HALF: ok = ~a[0] && (dev_w != 2'(lss_pkg::LSS_SZ_BYTE));
      default:              ok = (a == 2'b00) && (dev_w == 2'(lss_pkg::LSS_SZ_WORD));
    endcase
    return ok;
  endfunction

  // ---------------------------------------------------------------
  // State and register declarations
  // ---------------------------------------------------------------
  lss_pkg::lss_state_t   state_reg;
  lss_pkg::lss_state_t   state_next;
  lss_pkg::lss_mem_req_t mem_reg;
  lss_pkg::lss_mem_req_t mem_next;
  lss_pkg::lss_size_t    size_reg;
  logic                  tgt_reg;        // 1: peripheral port
  logic [31:0]           ctrl_reg;
  logic [31:0]           limit_reg;
  logic                  err_reg;
  logic                  err_next;
  logic [15:0]           count_reg;
  logic [31:0]           rd_mux;
  logic                  rd_hit;

  // ---------------------------------------------------------------
  // Request qualification
  // ---------------------------------------------------------------
  wire        ctrl_en    = ctrl_reg[lss_pkg::LSS_CTRL_EN_BIT];
  wire [1:0]  pb_width   = ctrl_reg[lss_pkg::LSS_CTRL_PW_MSB:lss_pkg::LSS_CTRL_PW_LSB];
  wire        in_wait    = (state_reg == lss_pkg::LSS_ST_WAIT);
  // Completion from the port that owns the transfer
  wire        cur_done   = in_wait && (tgt_reg ? pb_xfer_done : data_xfer_done);     // [RL15]
  wire [31:0] cur_rdata  = tgt_reg ? pb_rdata : lmb_rdata;
  // Port choice: address below the limit goes local if both ports exist
  wire        below_lim  = core_req.addr < limit_reg;
  wire        new_tgt    = data_side_local_mem_en
                           ? (data_side_periph_bus_en && !below_lim) : 1'b1;          // [RL7]
  // Local memory is word wide; peripheral width is set by software
  wire [1:0]  dev_width  = new_tgt ? pb_width : 2'(lss_pkg::LSS_SZ_WORD);
  wire        legal      = req_ok(core_req.size, core_req.addr[1:0], dev_width);      // [RL1] [RL2] [RL6]
  // Next request taken when idle or in the cycle its predecessor completes;
  // a refused one waits for idle so its answer never merges with a completion
  wire        chain_ok   = cur_done && legal;                                         // [RL9] [RL10]
  wire        take       = core_req.valid && ctrl_en && (!in_wait || chain_ok);     // [RL9] [RL10]
  wire        issue      = take && legal;
  wire        refuse     = take && !legal;                                            // [RL2]
  wire [3:0]  new_be     = lane_sel(core_req.size, core_req.addr[1:0]);

  // ---------------------------------------------------------------
  // Store steering: lane 0 is bits 31:24
  // ---------------------------------------------------------------
  // Byte lanes hold the same value either ordering, only wider items move
  wire [31:0] st_byte    = {4{core_req.wdata[7:0]}};                                  // [RL5] [RL12]
  wire [31:0] st_half    = {2{core_req.wdata[15:0]}};                                 // [RL5] [RL11]
  wire [31:0] st_data    = (core_req.size == lss_pkg::LSS_SZ_BYTE) ? st_byte :
                           (core_req.size == lss_pkg::LSS_SZ_HALF) ? st_half :
                           core_req.wdata;                                            // [RL5] [RL11]

  // ---------------------------------------------------------------
  // Load steering
  // ---------------------------------------------------------------
  logic [7:0] rd_lane [4];
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      // Lane gi sits at byte address gi, most significant first
      assign rd_lane[gi] = cur_rdata[31 - 8*gi -: 8];                                 // [RL11]
    end
  endgenerate

  wire [1:0]  lo_addr    = mem_reg.addr[1:0];
  wire [31:0] ld_byte    = {24'h00_0000, rd_lane[lo_addr]};                           // [RL4] [RL17] [RL12]
  wire [31:0] ld_half    = lo_addr[1] ? {16'h0000, rd_lane[2], rd_lane[3]}
                                      : {16'h0000, rd_lane[0], rd_lane[1]};           // [RL4] [RL17]
  wire [31:0] ld_data    = (size_reg == lss_pkg::LSS_SZ_BYTE) ? ld_byte :
                           (size_reg == lss_pkg::LSS_SZ_HALF) ? ld_half :
                           cur_rdata;                                                 // [RL4]

  // ---------------------------------------------------------------
  // Sequencer next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    mem_next   = mem_reg;
    // Strobe marks only the first cycle of a transfer
    mem_next.addr_strobe = 1'b0;                                                      // [RL13]
    if (issue) begin
      state_next           = lss_pkg::LSS_ST_WAIT;
      mem_next.addr        = core_req.addr;
      mem_next.byte_en     = new_be;                                                  // [RL3]
      mem_next.wdata       = st_data;
      mem_next.addr_strobe = 1'b1;                                                    // [RL13]
      // Same-type follow-on keeps its strobe high, other type swaps
      mem_next.read_strobe  = !core_req.wr;                                           // [RL14]
      mem_next.write_strobe = core_req.wr;                                            // [RL14]
    end else if (cur_done) begin
      state_next            = lss_pkg::LSS_ST_IDLE;
      // Strobes fall after done; write data stays until the next transfer
      mem_next.read_strobe  = 1'b0;                                                   // [RL14] [RL16]
      mem_next.write_strobe = 1'b0;                                                   // [RL14]
    end
  end

  // ---------------------------------------------------------------
  // Sequencer registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= lss_pkg::LSS_ST_IDLE;
      mem_reg   <= '0;
      size_reg  <= lss_pkg::LSS_SZ_WORD;
      tgt_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      mem_reg   <= mem_next;
      if (issue) begin
        size_reg <= core_req.size;
        tgt_reg  <= new_tgt;
      end
    end
  end

  // ---------------------------------------------------------------
  // Port outputs: strobes go only to the owning port
  // ---------------------------------------------------------------
  wire next_tgt  = issue ? new_tgt : tgt_reg;
  // Owner of the transfer in the next cycle
  wire lmb_owns  = !next_tgt;
  wire pb_owns   = next_tgt;

  // Local memory port: address, lanes and data copied, strobes gated
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lmb_req <= '0;
    end else begin
      lmb_req              <= mem_next;
      lmb_req.addr_strobe  <= mem_next.addr_strobe && lmb_owns;   // [RL13]
      lmb_req.read_strobe  <= mem_next.read_strobe && lmb_owns;   // [RL14]
      lmb_req.write_strobe <= mem_next.write_strobe && lmb_owns;  // [RL14]
    end
  end

  // Peripheral port: same copy, strobes only while it owns the transfer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pb_req <= '0;
    end else begin
      pb_req               <= mem_next;
      pb_req.addr_strobe   <= mem_next.addr_strobe && pb_owns;    // [RL13]
      pb_req.read_strobe   <= mem_next.read_strobe && pb_owns;    // [RL14]
      pb_req.write_strobe  <= mem_next.write_strobe && pb_owns;   // [RL14]
    end
  end

  // ---------------------------------------------------------------
  // Core answer
  // ---------------------------------------------------------------
  // Acceptance pulse registered on the edge that took the request
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_req_ack <= 1'b0;
    end else begin
      core_req_ack <= take;
    end
  end

  // Completion or refusal answer, one pulse per taken request
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_rsp     <= '0;
    end else begin
      // Refusals answer one cycle after the take, with no port activity
      core_rsp.done  <= cur_done || refuse;
      core_rsp.err   <= refuse && !cur_done;                                          // [RL2]
      // Read data latched on the edge done is sampled
      if (cur_done && !mem_reg.write_strobe) begin
        core_rsp.rdata <= ld_data;                                                    // [RL15] [RL4]
      end
    end
  end

  // ---------------------------------------------------------------
  // APB slave: one wait state, then pready
  // ---------------------------------------------------------------
  wire apb_access = psel && penable;
  wire apb_fire   = apb_access && pready;
  wire apb_wr     = apb_fire && pwrite;

  // Read decode
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (paddr == lss_pkg::LSS_OFF_CTRL) begin
      rd_mux = ctrl_reg;
    end else if (paddr == lss_pkg::LSS_OFF_LIMIT) begin
      rd_mux = limit_reg;
    end else if (paddr == lss_pkg::LSS_OFF_STATUS) begin
      rd_mux[lss_pkg::LSS_ST_BUSY_BIT] = in_wait;
      rd_mux[lss_pkg::LSS_ST_ERR_BIT]  = err_reg;
      rd_mux[lss_pkg::LSS_ST_TGT_BIT]  = tgt_reg;
      // Build configuration visible to software
      rd_mux[lss_pkg::LSS_ST_CFG_LSB +: 4] = {instr_side_local_mem_en, instr_side_periph_bus_en,
                                              data_side_local_mem_en, data_side_periph_bus_en}; // [RL7] [RL8]
    end else if (paddr == lss_pkg::LSS_OFF_COUNT) begin
      rd_mux = {16'h0000, count_reg};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Sticky refusal flag: a new refusal beats a same-cycle clear
  always_comb begin
    err_next = err_reg;
    if (apb_wr && (paddr == lss_pkg::LSS_OFF_STATUS) && pwdata[lss_pkg::LSS_ST_ERR_BIT]) begin
      err_next = 1'b0;
    end
    if (refuse) begin
      err_next = 1'b1;                                                                // [RL2]
    end
  end

  // First access cycle: the one wait state before pready
  wire apb_first  = apb_access && !pready;

  // Bus handshake: pready for one cycle after the wait state
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_first;
      pslverr <= apb_first && !rd_hit;
    end
  end

  // Read data stands with pready and is zero otherwise
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= (apb_first && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Software registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg  <= lss_pkg::LSS_CTRL_RESET;
      limit_reg <= lss_pkg::LSS_LIMIT_RESET;
    end else begin
      // Only enable and peripheral width are kept
      if (apb_wr && (paddr == lss_pkg::LSS_OFF_CTRL)) begin
        ctrl_reg <= {29'h0000_0000, pwdata[lss_pkg::LSS_CTRL_PW_MSB:0]};
      end
      if (apb_wr && (paddr == lss_pkg::LSS_OFF_LIMIT)) begin
        limit_reg <= pwdata;
      end
    end
  end

  // Sticky refusal flag register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= err_next;                // [RL2]
    end
  end

  // Completed transfers, wrapping at the top
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= lss_pkg::LSS_COUNT_RESET;
    end else if (cur_done) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

endmodule // lss_top

/* verilog/lss_pkg.sv */
package lss_pkg;

  // ---------------------------------------------------------------
  // Transfer sizes and sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {LSS_SZ_BYTE, LSS_SZ_HALF, LSS_SZ_WORD} lss_size_t;
  typedef enum logic {LSS_ST_IDLE, LSS_ST_WAIT} lss_state_t;

  // ---------------------------------------------------------------
  // Register map (APB byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] LSS_OFF_CTRL   = 12'h000;
  localparam logic [11:0] LSS_OFF_LIMIT  = 12'h004;
  localparam logic [11:0] LSS_OFF_STATUS = 12'h008;
  localparam logic [11:0] LSS_OFF_COUNT  = 12'h00c;

  // Control fields
  localparam int          LSS_CTRL_EN_BIT   = 0;
  localparam int          LSS_CTRL_PW_LSB   = 1;
  localparam int          LSS_CTRL_PW_MSB   = 2;
  localparam logic [31:0] LSS_CTRL_RESET    = 32'h0000_0005;
  localparam logic [31:0] LSS_LIMIT_RESET   = 32'h0001_0000;

  // Status fields
  localparam int          LSS_ST_BUSY_BIT   = 0;
  localparam int          LSS_ST_ERR_BIT    = 1;
  localparam int          LSS_ST_TGT_BIT    = 2;
  localparam int          LSS_ST_CFG_LSB    = 4;
  localparam logic [15:0] LSS_COUNT_RESET   = 16'h0000;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  // Lane 0 is bits 31:24 (lowest byte address); byte_en[3] selects lane 0
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
    logic        addr_strobe;
    logic        read_strobe;
    logic        write_strobe;
  } lss_mem_req_t;

  typedef struct packed {
    logic        valid;
    logic        wr;
    lss_size_t   size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } lss_core_req_t;

  typedef struct packed {
    logic        done;
    logic        err;
    logic [31:0] rdata;
  } lss_core_rsp_t;

endpackage

/* tb/lss_mem_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Memory or slave behind one data port
// ----------------------------------------
module lss_mem_model (
  input  wire logic                  sys_clk,
  input  wire lss_pkg::lss_mem_req_t req,
  input  wire logic [1:0]            lat,
  output logic [31:0]                rdata,
  output logic                       done
);
  logic [31:0] mem [4];
  logic [31:0] last;
  logic [3:0]  be;
  logic [1:0]  idx;
  logic [1:0]  cnt;
  logic        busy = 1'b0;
  wire  [1:0]  w_idx = req.addr_strobe ? req.addr[3:2] : idx;
  wire  [3:0]  w_be  = req.addr_strobe ? req.byte_en : be;

  // Completion after lat cycles, zero means same cycle
  assign done  = req.addr_strobe ? (lat == 2'h0) : (busy && cnt == lat);
  // Big-endian word, lane 0 in bits 31:24; idle bus toggles
  assign rdata = (done && req.read_strobe) ? mem[w_idx] : ~last;

  // Address is only valid with the strobe, so keep it
  always @(posedge sys_clk) begin
    last <= rdata;
    if (req.addr_strobe) begin
      idx  <= req.addr[3:2];
      be   <= req.byte_en;
      busy <= lat != 2'h0;
      cnt  <= 2'h1;
    end else if (busy) begin
      busy <= cnt != lat;
      cnt  <= cnt + 2'h1;
    end
    for (int i = 0; i < 4; i++) begin
      if (done && req.write_strobe && w_be[i]) mem[w_idx][i*8+:8] <= req.wdata[i*8+:8];
    end
  end
endmodule // lss_mem_model

/* tb/lss_assertions.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Port checks of the steering block
// ----------------------------------------
module lss_assertions (
  input wire logic                   sys_clk,
  input wire logic                   rst_b,
  input wire lss_pkg::lss_core_req_t core_req,
  input wire logic                   core_req_ack,
  input wire lss_pkg::lss_core_rsp_t core_rsp,
  input wire lss_pkg::lss_mem_req_t  lmb_req,
  input wire logic [31:0]            lmb_rdata,
  input wire logic                   data_xfer_done,
  input wire lss_pkg::lss_mem_req_t  pb_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  lss_pkg::lss_core_req_t rq;
  // Short names for a started transfer
  wire       as_l = lmb_req.addr_strobe;
  wire       go   = core_req_ack && (as_l || pb_req.addr_strobe);
  wire       dn   = data_xfer_done;
  wire [3:0] be   = lmb_req.byte_en;
  wire       sb   = rq.size == lss_pkg::LSS_SZ_BYTE;

  // Request as seen at the edge that took it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) rq <= '0;
    else rq <= core_req;
  end

  property p_as_once; as_l && !dn |=> !as_l; endproperty
  a_as_once: assert property (p_as_once) else $error("address strobe too long");
  property p_be_byte; go && sb |-> be == 4'h8 >> rq.addr[1:0]; endproperty
  a_be_byte: assert property (p_be_byte) else $error("byte lane select wrong");
  property p_be_wide; go && !sb |-> be == (rq.size[1] ? 4'hf : rq.addr[1] ? 4'h3 : 4'hc); endproperty
  a_be_wide: assert property (p_be_wide) else $error("wide lane select wrong");
  property p_st_byte; go && rq.wr && sb |-> lmb_req.wdata == {4{rq.wdata[7:0]}}; endproperty
  a_st_byte: assert property (p_st_byte) else $error("byte not replicated");
  property p_wd_hold; lmb_req.write_strobe && !as_l |-> $stable(lmb_req.wdata); endproperty
  a_wd_hold: assert property (p_wd_hold) else $error("write data moved");
  property p_ws_fall; lmb_req.write_strobe && dn |=> !lmb_req.write_strobe || as_l; endproperty
  a_ws_fall: assert property (p_ws_fall) else $error("write strobe stuck");
  property p_rsp; (lmb_req.read_strobe || lmb_req.write_strobe) && dn |=> core_rsp.done && !core_rsp.err; endproperty
  a_rsp: assert property (p_rsp) else $error("no response after done");
  property p_ld_byte; lmb_req.read_strobe && dn && be == 4'h4 |=> core_rsp.rdata == {24'h0, $past(lmb_rdata[23:16])};
  endproperty
  a_ld_byte: assert property (p_ld_byte) else $error("byte load misplaced");
  property p_refuse; core_req_ack && rq.size[1] && rq.addr[1:0] != 2'h0 |-> core_rsp.err && !go; endproperty
  a_refuse: assert property (p_refuse) else $error("misaligned word not refused");
endmodule // lss_assertions

bind lss_top lss_assertions lss_assertions_inst (.sys_clk(sys_clk), .rst_b(rst_b), .core_req(core_req),
  .core_req_ack(core_req_ack), .core_rsp(core_rsp), .lmb_req(lmb_req), .lmb_rdata(lmb_rdata),
  .data_xfer_done(data_xfer_done), .pb_req(pb_req));

/* tb/tb_top.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Bench for the load/store steering block
// ----------------------------------------
module tb_top;
  logic                   sys_clk = 1'b0;
  logic                   rst_b   = 1'b0;
  logic [11:0]            paddr   = 12'h000;
  logic                   psel    = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite  = 1'b0;
  logic [31:0]            pwdata  = 32'h0;
  logic [31:0]            prdata, lmb_rdata, pb_rdata, q;
  logic                   pready, pslverr, core_req_ack, data_xfer_done, pb_xfer_done, e;
  lss_pkg::lss_core_req_t core_req = '0;
  lss_pkg::lss_core_rsp_t core_rsp;
  lss_pkg::lss_mem_req_t  lmb_req, pb_req;
  logic [1:0]             lat_l = 2'h1;
  logic [1:0]             lat_p = 2'h2;
  int                     fail_count = 0;
  int                     num_checks = 0;

  // Core clock
  always #20 sys_clk = ~sys_clk;

  // Block and a slave model on each data port
  lss_top lss_top_inst (.sys_clk(sys_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_req(core_req), .core_req_ack(core_req_ack), .core_rsp(core_rsp), .lmb_req(lmb_req),
    .lmb_rdata(lmb_rdata), .data_xfer_done(data_xfer_done), .pb_req(pb_req), .pb_rdata(pb_rdata),
    .pb_xfer_done(pb_xfer_done));
  lss_mem_model lss_mem_model_inst (.sys_clk(sys_clk), .req(lmb_req), .lat(lat_l), .rdata(lmb_rdata),
    .done(data_xfer_done));
  lss_mem_model pb_lss_mem_model_inst (.sys_clk(sys_clk), .req(pb_req), .lat(lat_p), .rdata(pb_rdata),
    .done(pb_xfer_done));

  task chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic er);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(pready, 1'b1);
    r = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task xfer(input logic w, input lss_pkg::lss_size_t s, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic er);
    int n;
    @(posedge sys_clk);
    core_req <= '{1'b1, w, s, a, d};
    @(posedge sys_clk);
    core_req.valid <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (core_rsp.done !== 1'b1 && n < 20);
    chk(core_rsp.done, 1'b1);
    r = core_rsp.rdata;
    er = core_rsp.err;
  endtask

  task t_regs;
    apb(1'b0, lss_pkg::LSS_OFF_STATUS, 32'h0, q, e);
    chk({28'h0, q[7:4]}, 32'hf);
    apb(1'b1, 12'h010, 32'h1, q, e);
    chk(e, 1'b1);
  endtask

  task t_lanes;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, lss_pkg::LSS_SZ_BYTE, i, 32'hdead_be10 + i, q, e);
      chk(e, 1'b0);
    end
    xfer(1'b0, lss_pkg::LSS_SZ_WORD, 32'h0, 32'h0, q, e);
    chk(q, 32'h1011_1213);
    xfer(1'b1, lss_pkg::LSS_SZ_WORD, 32'h4, 32'h1112_1314, q, e);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, lss_pkg::LSS_SZ_BYTE, 32'h4 + i, 32'h0, q, e);
      chk(q, 32'h11 + i);
    end
    for (int i = 0; i < 2; i++) begin
      xfer(1'b0, lss_pkg::LSS_SZ_HALF, 32'h4 + 2 * i, 32'h0, q, e);
      chk(q, 32'h1112 + 32'h0202 * i);
      xfer(1'b1, lss_pkg::LSS_SZ_HALF, 32'h8 + 2 * i, 32'h5555_a1b2 + 32'h2222 * i, q, e);
    end
    xfer(1'b0, lss_pkg::LSS_SZ_WORD, 32'h8, 32'h0, q, e);
    chk(q, 32'ha1b2_c3d4);
  endtask

  task t_refuse;
    xfer(1'b0, lss_pkg::LSS_SZ_WORD, 32'h2, 32'h0, q, e);
    chk(e, 1'b1);
    xfer(1'b1, lss_pkg::LSS_SZ_HALF, 32'h1, 32'h0, q, e);
    chk(e, 1'b1);
    apb(1'b0, lss_pkg::LSS_OFF_STATUS, 32'h0, q, e);
    chk(q[lss_pkg::LSS_ST_ERR_BIT], 1'b1);
    // Writing one to the flag clears it
    apb(1'b1, lss_pkg::LSS_OFF_STATUS, 32'h1 << lss_pkg::LSS_ST_ERR_BIT, q, e);
    apb(1'b0, lss_pkg::LSS_OFF_STATUS, 32'h0, q, e);
    chk(q[lss_pkg::LSS_ST_ERR_BIT], 1'b0);
  endtask

  // Every size against every peripheral width
  task t_narrow;
    for (int w = 0; w < 3; w++) begin
      apb(1'b1, lss_pkg::LSS_OFF_CTRL, {29'h0, w[1:0], 1'b1}, q, e);
      for (int s = 0; s < 3; s++) begin
        xfer(1'b1, lss_pkg::lss_size_t'(s), 32'h2_0000, 32'h0a0b_0c0d, q, e);
        chk(e, s > w);
      end
    end
    xfer(1'b0, lss_pkg::LSS_SZ_BYTE, 32'h2_0000, 32'h0, q, e);
    chk(q, 32'h0a);
  endtask

  // Two transfers, the second held until the done edge
  task t_b2b(input logic w, input logic [1:0] l, input int gap);
    int n;
    int f;
    int g;
    @(posedge sys_clk);
    lat_l    <= l;
    core_req <= '{1'b1, w, lss_pkg::LSS_SZ_WORD, 32'h8, 32'h0};
    @(posedge sys_clk);
    core_req.addr <= 32'hc;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (data_xfer_done !== 1'b1 && n < 20);
    chk(data_xfer_done, 1'b1);
    @(posedge sys_clk);
    core_req.valid <= 1'b0;
    f = -1;
    g = 99;
    for (n = 0; n < 8; n++) begin
      @(negedge sys_clk);
      if (core_rsp.done === 1'b1 && f >= 0 && g == 99) g = n;
      if (core_rsp.done === 1'b1 && f < 0) f = n;
    end
    chk(g - f, gap);
  endtask

  task tally_and_finish;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs;
    t_lanes;
    t_refuse;
    t_narrow;
    t_b2b(1'b1, 2'h1, 2);
    t_b2b(1'b0, 2'h0, 1);
    tally_and_finish;
  end

  // Watchdog
  initial begin
    #2000000;
    fail_count++;
    tally_and_finish;
  end
endmodule // tb_top
